// ### logic/ukv_user_key_verify.sv
// User key verify command interpreter: receive, check, verify, answer
`timescale 1ns/100ps

// ************************************************************
// User key verify command
// ************************************************************
module ukv_user_key_verify #(
   parameter int FIFO_DEPTH = ukv_pkg::TX_FIFO_DEPTH
) (
   input  wire logic        CLOCK,
   input  wire logic        RESETN,
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_VALID,
   output logic             RX_READY,
   output logic [7:0]       TX_DATA,
   output logic             TX_VALID,
   input  wire logic        TX_READY,
   input  wire logic [31:0] USER_AREA_START,
   input  wire logic [31:0] USER_AREA_END,
   input  wire logic [31:0] DATA_AREA_START,
   input  wire logic [31:0] DATA_AREA_END,
   input  wire logic [7:0]  USER_AREA_WRITE_UNIT,
   input  wire logic [7:0]  DATA_AREA_WRITE_UNIT,
   input  wire logic [31:0] ACCESS_LIMIT_LOW,
   input  wire logic [31:0] ACCESS_LIMIT_HIGH,
   output logic             VERIFY_REQ,
   output logic [31:0]      VERIFY_ADDR,
   output logic [7:0]       VERIFY_TYPE,
   input  wire logic        VERIFY_DONE,
   input  wire logic        VERIFY_MATCH,
   input  wire logic        VERIFY_FAULT,
   output logic             UNRESPONSIVE
);

   // ************************************************************
   // Helpers
   // ************************************************************
   // Key index size in bytes for each supported key type; zero means unsupported
   function automatic logic [15:0] key_index_size(input logic [7:0] kind);
      case (kind)
         8'h19, 8'h1f, 8'h28:                      key_index_size = 16'd68;
         8'h1a, 8'h1b, 8'h1d, 8'h23, 8'h26, 8'h27,
         8'hff:                                    key_index_size = 16'd52;
         8'h1c, 8'h21, 8'h22, 8'h29, 8'h2a, 8'h2b: key_index_size = 16'd84;
         8'h1e:                                    key_index_size = 16'd116;
         8'h20:                                    key_index_size = 16'd148;
         8'h24:                                    key_index_size = 16'd180;
         8'h25:                                    key_index_size = 16'd100;
         8'hfe:                                    key_index_size = 16'd292;
         default:                                  key_index_size = 16'd0;
      endcase
   endfunction

   function automatic logic in_range(input logic [32:0] lo,
                                     input logic [32:0] hi,
                                     input logic [31:0] start,
                                     input logic [31:0] stop);
      in_range = (lo >= {1'b0, start}) && (hi <= {1'b0, stop});
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   ukv_pkg::ukv_state_e state_r;
   logic [15:0]         len_r;
   logic [15:0]         cnt_r;
   logic [7:0]          sum_r;
   logic [7:0]          cmd_r;
   logic [31:0]         key_address_field_r;
   logic [7:0]          key_type_r;
   logic [7:0]          sts_r;
   logic                ok_r;
   logic [3:0]          tx_idx_r;
   logic [7:0]          tx_sum_r;
   logic                verify_req_r;

   logic                rx_take;
   logic [7:0]          sum_nxt;
   logic [15:0]         ksize;
   logic [32:0]         range_end;
   logic                start_user;
   logic                start_data;
   logic                end_user;
   logic                end_data;
   logic                whole_user;
   logic                whole_data;
   logic [7:0]          area_write_unit;
   logic                misaligned;
   logic                reachable;
   logic [7:0]          param_sts;
   logic [7:0]          tx_byte;
   logic                tx_push;

   ukv_stream_if #(.WIDTH(ukv_pkg::TX_FIFO_WIDTH)) fill_s ();
   ukv_stream_if #(.WIDTH(ukv_pkg::TX_FIFO_WIDTH)) drain_s ();

   // ************************************************************
   // Receive side
   // ************************************************************
   // Ready only while a packet is being taken; idle during checks and answer
   assign RX_READY = (state_r == ukv_pkg::ST_WAIT_START) || (state_r == ukv_pkg::ST_LEN_HIGH)
                  || (state_r == ukv_pkg::ST_LEN_LOW) || (state_r == ukv_pkg::ST_BODY)
                  || (state_r == ukv_pkg::ST_SUM) || (state_r == ukv_pkg::ST_END);
   assign rx_take  = RX_VALID & RX_READY;
   assign sum_nxt  = sum_r + RX_DATA;

   // ************************************************************
   // Parameter checks
   // ************************************************************
   assign ksize      = key_index_size(key_type_r);
   assign range_end  = {1'b0, key_address_field_r} + {17'h00000, ksize} - 33'h000000001;
   assign start_user = in_range({1'b0, key_address_field_r}, {1'b0, key_address_field_r}, USER_AREA_START, USER_AREA_END);
   assign start_data = in_range({1'b0, key_address_field_r}, {1'b0, key_address_field_r}, DATA_AREA_START, DATA_AREA_END);
   assign end_user   = in_range(range_end, range_end, USER_AREA_START, USER_AREA_END);
   assign end_data   = in_range(range_end, range_end, DATA_AREA_START, DATA_AREA_END);
   assign whole_user = in_range({1'b0, key_address_field_r}, range_end, USER_AREA_START, USER_AREA_END);
   assign whole_data = in_range({1'b0, key_address_field_r}, range_end, DATA_AREA_START, DATA_AREA_END);
   assign area_write_unit        = start_data ? DATA_AREA_WRITE_UNIT : USER_AREA_WRITE_UNIT;
   // Write units are powers of two, so the grid test is a mask
   assign misaligned = (key_address_field_r[7:0] & (area_write_unit - 8'h01)) != 8'h00;
   assign reachable  = in_range({1'b0, key_address_field_r}, range_end, ACCESS_LIMIT_LOW, ACCESS_LIMIT_HIGH);

   // First failing check wins, in priority order
   always_comb begin
      if (ksize == 16'd0) begin
         param_sts = ukv_pkg::STS_PARAM_ERR;
      end else if (!whole_user && !whole_data) begin
         param_sts = ukv_pkg::STS_PARAM_ERR;
      end else if ((start_user && end_data) || (start_data && end_user)) begin
         param_sts = ukv_pkg::STS_PARAM_ERR;
      end else if (area_write_unit == 8'h00) begin
         param_sts = ukv_pkg::STS_PARAM_ERR;
      end else if (misaligned) begin
         param_sts = ukv_pkg::STS_PARAM_ERR;
      end else if (!reachable) begin
         param_sts = ukv_pkg::STS_ADDRESS_ERR;
      end else begin
         param_sts = ukv_pkg::STS_OK;
      end
   end

   // ************************************************************
   // Command sequencer
   // ************************************************************
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         state_r <= ukv_pkg::ST_WAIT_START;
         sts_r   <= ukv_pkg::STS_OK;
         ok_r    <= 1'b0;
      end else begin
         unique case (state_r)
            ukv_pkg::ST_WAIT_START: begin
               if (rx_take && RX_DATA == ukv_pkg::CMD_START) begin
                  state_r <= ukv_pkg::ST_LEN_HIGH;
               end
            end
            ukv_pkg::ST_LEN_HIGH: begin
               if (rx_take) begin
                  state_r <= ukv_pkg::ST_LEN_LOW;
               end
            end
            ukv_pkg::ST_LEN_LOW: begin
               if (rx_take) begin
                  state_r <= ({len_r[15:8], RX_DATA} == 16'h0000) ?
                             ukv_pkg::ST_SUM : ukv_pkg::ST_BODY;
               end
            end
            ukv_pkg::ST_BODY: begin
               if (rx_take && cnt_r == len_r - 16'h0001) begin
                  state_r <= ukv_pkg::ST_SUM;
               end
            end
            ukv_pkg::ST_SUM: begin
               if (rx_take) begin
                  state_r <= ukv_pkg::ST_END;
               end
            end
            ukv_pkg::ST_END: begin
               if (rx_take) begin
                  ok_r    <= 1'b0;
                  state_r <= ukv_pkg::ST_SEND;
                  if (cmd_r != ukv_pkg::CMD_CODE) begin
                     state_r <= ukv_pkg::ST_WAIT_START;
                  end else if (RX_DATA != ukv_pkg::PACKET_END) begin
                     sts_r <= ukv_pkg::STS_PACKET_ERR;
                  end else if (sum_r != 8'h00) begin
                     sts_r <= ukv_pkg::STS_CHECKSUM_ERR;
                  end else if (len_r == 16'h0000 || len_r > ukv_pkg::MAX_FORMAT_LEN) begin
                     sts_r <= ukv_pkg::STS_PACKET_ERR;
                  end else if (len_r != ukv_pkg::CMD_LEN) begin
                     sts_r <= ukv_pkg::STS_PACKET_ERR;
                  end else begin
                     state_r <= ukv_pkg::ST_PARAM;
                  end
               end
            end
            ukv_pkg::ST_PARAM: begin
               sts_r <= param_sts;
               // Errors skip verification and go straight to the answer
               state_r <= (param_sts == ukv_pkg::STS_OK) ?
                          ukv_pkg::ST_VERIFY : ukv_pkg::ST_SEND;
            end
            ukv_pkg::ST_VERIFY: begin
               if (VERIFY_FAULT) begin
                  state_r <= ukv_pkg::ST_HANG;
               end else if (VERIFY_DONE) begin
                  ok_r    <= VERIFY_MATCH;
                  sts_r   <= VERIFY_MATCH ? ukv_pkg::STS_OK
                                          : ukv_pkg::STS_TRUSTED_ERR;
                  state_r <= ukv_pkg::ST_SEND;
               end
            end
            ukv_pkg::ST_SEND: begin
               if (tx_push && tx_idx_r == ukv_pkg::RESP_IDX_LAST) begin
                  state_r <= ukv_pkg::ST_WAIT_START;
               end
            end
            ukv_pkg::ST_HANG: begin
               // Only a reset brings the block back
               state_r <= ukv_pkg::ST_HANG;
            end
            default: begin
               state_r <= ukv_pkg::ST_WAIT_START;
            end
         endcase
      end
   end

   // ************************************************************
   // Packet capture
   // ************************************************************
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         len_r      <= 16'h0000;
         cnt_r      <= 16'h0000;
         sum_r      <= 8'h00;
         cmd_r      <= 8'h00;
         key_address_field_r     <= 32'h00000000;
         key_type_r <= 8'h00;
      end else if (rx_take) begin
         unique case (state_r)
            ukv_pkg::ST_WAIT_START: begin
               sum_r <= 8'h00;
               cmd_r <= 8'h00;
            end
            ukv_pkg::ST_LEN_HIGH: begin
               len_r[15:8] <= RX_DATA;
               sum_r       <= sum_nxt;
            end
            ukv_pkg::ST_LEN_LOW: begin
               len_r[7:0] <= RX_DATA;
               sum_r      <= sum_nxt;
               cnt_r      <= 16'h0000;
            end
            ukv_pkg::ST_BODY: begin
               sum_r <= sum_nxt;
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == ukv_pkg::BODY_CMD_IDX) begin
                  cmd_r <= RX_DATA;
               end
               if (cnt_r >= ukv_pkg::BODY_ADDR_FIRST && cnt_r <= ukv_pkg::BODY_ADDR_LAST) begin
                  key_address_field_r <= {key_address_field_r[23:0], RX_DATA};
               end
               if (cnt_r == ukv_pkg::BODY_TYPE_IDX) begin
                  key_type_r <= RX_DATA;
               end
            end
            ukv_pkg::ST_SUM: begin
               sum_r <= sum_nxt;
            end
            default: begin
               sum_r <= sum_r;
            end
         endcase
      end
   end

   // ************************************************************
   // Trusted subsystem request
   // ************************************************************
   // Read-only compare: no write path to memory exists here
   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         verify_req_r <= 1'b0;
      end else if (state_r == ukv_pkg::ST_PARAM && param_sts == ukv_pkg::STS_OK) begin
         verify_req_r <= 1'b1;
      end else if (VERIFY_DONE || VERIFY_FAULT) begin
         verify_req_r <= 1'b0;
      end
   end

   assign VERIFY_REQ   = verify_req_r;
   assign VERIFY_ADDR  = key_address_field_r;
   assign VERIFY_TYPE  = key_type_r;
   assign UNRESPONSIVE = (state_r == ukv_pkg::ST_HANG);

   // ************************************************************
   // Answer builder
   // ************************************************************
   always_comb begin
      unique case (tx_idx_r)
         4'h0:                  tx_byte = ukv_pkg::DATA_PACKET_START;
         4'h1:                  tx_byte = ukv_pkg::RESP_LEN_HIGH;
         4'h2:                  tx_byte = ukv_pkg::RESP_LEN_LOW;
         ukv_pkg::RESP_IDX_RES: tx_byte = ok_r ? ukv_pkg::RESP_OK_CODE
                                              : ukv_pkg::RESP_ERR_CODE;
         ukv_pkg::RESP_IDX_STS: tx_byte = sts_r;
         ukv_pkg::RESP_IDX_SUM: tx_byte = ok_r ? ukv_pkg::RESP_OK_SUM
                                              : 8'(8'h00 - tx_sum_r);
         ukv_pkg::RESP_IDX_LAST: tx_byte = ukv_pkg::PACKET_END;
         4'h5, 4'h9:            tx_byte = ukv_pkg::UNUSED_CODE[31:24];
         4'h6, 4'ha:            tx_byte = ukv_pkg::UNUSED_CODE[23:16];
         4'h7, 4'hb:            tx_byte = ukv_pkg::UNUSED_CODE[15:8];
         4'h8, 4'hc:            tx_byte = ukv_pkg::UNUSED_CODE[7:0];
         default:               tx_byte = 8'h00;
      endcase
   end

   assign fill_s.data  = tx_byte;
   assign fill_s.valid = (state_r == ukv_pkg::ST_SEND);
   assign tx_push      = fill_s.valid & fill_s.ready;

   always_ff @(posedge CLOCK) begin
      if (!RESETN) begin
         tx_idx_r <= 4'h0;
         tx_sum_r <= 8'h00;
      end else if (state_r != ukv_pkg::ST_SEND) begin
         tx_idx_r <= 4'h0;
         tx_sum_r <= 8'h00;
      end else if (tx_push) begin
         tx_idx_r <= tx_idx_r + 4'h1;
         if (tx_idx_r != 4'h0 && tx_idx_r < ukv_pkg::RESP_IDX_SUM) begin
            tx_sum_r <= tx_sum_r + tx_byte;
         end
      end
   end

   // ************************************************************
   // Transmit buffer
   // ************************************************************
   // Host back-pressure fills the buffer and then stalls the answer builder
   ukv_fifo #(
      .WIDTH (ukv_pkg::TX_FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk   (CLOCK),
      .rst_n (RESETN),
      .in_s  (fill_s),
      .out_s (drain_s)
   );

   assign TX_DATA       = drain_s.data;
   assign TX_VALID      = drain_s.valid;
   assign drain_s.ready = TX_READY;

endmodule

// ### logic/ukv_pkg.sv
// Constants shared by the user key verify command block
package ukv_pkg;

   // ************************************************************
   // Framing bytes
   // ************************************************************
   localparam logic [7:0]  CMD_START        = 8'h01;
   localparam logic [7:0]  DATA_PACKET_START = 8'h81;
   localparam logic [7:0]  PACKET_END       = 8'h03;
   localparam logic [7:0]  CMD_CODE         = 8'h2b;
   localparam logic [7:0]  RESP_OK_CODE     = 8'h2b;
   localparam logic [7:0]  RESP_ERR_CODE    = 8'hab;
   localparam logic [7:0]  RESP_LEN_HIGH    = 8'h00;
   localparam logic [7:0]  RESP_LEN_LOW     = 8'h0a;
   localparam logic [7:0]  RESP_OK_SUM      = 8'hd6;
   localparam logic [31:0] UNUSED_CODE      = 32'hffffffff;

   // ************************************************************
   // Lengths and positions
   // ************************************************************
   localparam logic [15:0] CMD_LEN          = 16'h0006;
   localparam logic [15:0] MAX_FORMAT_LEN   = 16'h0100;
   localparam logic [15:0] BODY_CMD_IDX     = 16'h0000;
   localparam logic [15:0] BODY_ADDR_FIRST  = 16'h0001;
   localparam logic [15:0] BODY_ADDR_LAST   = 16'h0004;
   localparam logic [15:0] BODY_TYPE_IDX    = 16'h0005;
   localparam logic [3:0]  RESP_IDX_RES     = 4'h3;
   localparam logic [3:0]  RESP_IDX_STS     = 4'h4;
   localparam logic [3:0]  RESP_IDX_SUM     = 4'hd;
   localparam logic [3:0]  RESP_IDX_LAST    = 4'he;

   // ************************************************************
   // Status codes (values are arbitrary)
   // ************************************************************
   localparam logic [7:0]  STS_OK           = 8'h00;
   localparam logic [7:0]  STS_PACKET_ERR   = 8'hc1;
   localparam logic [7:0]  STS_CHECKSUM_ERR = 8'hc2;
   localparam logic [7:0]  STS_PARAM_ERR    = 8'hc3;
   localparam logic [7:0]  STS_ADDRESS_ERR  = 8'hd0;
   localparam logic [7:0]  STS_TRUSTED_ERR  = 8'hcc;

   // ************************************************************
   // Buffering
   // ************************************************************
   localparam int          TX_FIFO_WIDTH    = 8;
   localparam int          TX_FIFO_DEPTH    = 8;

   typedef enum logic [3:0] {
      ST_WAIT_START = 4'h0,
      ST_LEN_HIGH   = 4'h1,
      ST_LEN_LOW    = 4'h2,
      ST_BODY       = 4'h3,
      ST_SUM        = 4'h4,
      ST_END        = 4'h5,
      ST_PARAM      = 4'h6,
      ST_VERIFY     = 4'h7,
      ST_SEND       = 4'h8,
      ST_HANG       = 4'h9
   } ukv_state_e;

endpackage

// ### logic/ukv_stream_if.sv
// Valid/ready byte stream between the interpreter and its transmit buffer
`timescale 1ns/100ps
interface ukv_stream_if #(
   parameter int WIDTH = 8
);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;

   modport source (output data, output valid, input ready);
   modport sink   (input data, input valid, output ready);
endinterface

// ### logic/ukv_fifo.sv
// Transmit FIFO with a registered output stage
`timescale 1ns/100ps
module ukv_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic   clk,
   input  wire logic   rst_n,
   ukv_stream_if.sink   in_s,
   ukv_stream_if.source out_s
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      cnt_r;
   logic [WIDTH-1:0] data_r;
   logic             valid_r;
   logic             push;
   logic             pop;
   logic             load;
   logic             from_mem;
   logic             bypass;

   // Capacity counts the output stage, so full really means DEPTH words held
   assign in_s.ready = ({1'b0, cnt_r} + {{(AW+1){1'b0}}, valid_r}) < (AW+2)'(DEPTH);
   assign push       = in_s.valid & in_s.ready;
   assign pop        = valid_r & out_s.ready;
   assign load       = ~valid_r | pop;
   assign from_mem   = load & (cnt_r != '0);
   assign bypass     = load & (cnt_r == '0) & push;
   assign out_s.data  = data_r;
   assign out_s.valid = valid_r;

   always_ff @(posedge clk) begin
      if (push & ~bypass) begin
         mem_r[wr_ptr_r] <= in_s.data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else begin
         if (push & ~bypass) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (from_mem) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push & ~bypass) - (AW+1)'(from_mem);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         data_r  <= '0;
         valid_r <= 1'b0;
      end else if (load) begin
         valid_r <= from_mem | bypass;
         if (from_mem) begin
            data_r <= mem_r[rd_ptr_r];
         end else if (bypass) begin
            data_r <= in_s.data;
         end
      end
   end
endmodule

// ### verif/ukv_host_model.sv
// Host programmer model: collects answer bytes, stalling on request
`timescale 1ns/100ps
module ukv_host_model (
   input  wire logic       clk,
   input  wire logic       slow,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready
);
   logic [7:0] got [0:255];
   int         cnt = 0;
   logic [1:0] ph_r = 2'h0;
   // Slow mode takes one byte in four so the buffer backs up
   assign tx_ready = !slow || ph_r == 2'h3;
   always_ff @(posedge clk) begin
      ph_r <= ph_r + 2'h1;
      if (tx_valid && tx_ready) begin
         got[cnt % 256] <= tx_data;
         cnt            <= cnt + 1;
      end
   end
endmodule

// ### verif/ukv_user_key_verify_properties.sv
// Port-level assertions for the user key verify block
`timescale 1ns/100ps
module ukv_user_key_verify_properties (
   input wire logic        CLOCK,
   input wire logic        RESETN,
   input wire logic        RX_READY,
   input wire logic [7:0]  TX_DATA,
   input wire logic        TX_VALID,
   input wire logic        TX_READY,
   input wire logic [31:0] VERIFY_ADDR,
   input wire logic        VERIFY_REQ,
   input wire logic        VERIFY_DONE,
   input wire logic        VERIFY_MATCH,
   input wire logic        VERIFY_FAULT,
   input wire logic        UNRESPONSIVE
);
   default clocking dc @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("answer byte lost while stalled");
   req_hold_a: assert property (VERIFY_REQ && !VERIFY_DONE && !VERIFY_FAULT
      |=> VERIFY_REQ && $stable(VERIFY_ADDR)) else $error("verify request unstable");
   req_drop_a: assert property (VERIFY_REQ && VERIFY_DONE |=> !VERIFY_REQ)
      else $error("verify request held after done");
   fault_hang_a: assert property (VERIFY_REQ && VERIFY_FAULT |=> UNRESPONSIVE)
      else $error("fault did not hang block");
   hang_quiet_a: assert property (UNRESPONSIVE |-> !RX_READY && !VERIFY_REQ)
      else $error("hung block still active");
   hang_stays_a: assert property (UNRESPONSIVE |=> UNRESPONSIVE)
      else $error("hang released without reset");
   ok_start_a: assert property (VERIFY_REQ && VERIFY_DONE && VERIFY_MATCH
      |-> ##2 TX_VALID && TX_DATA == 8'h81) else $error("answer start late");
   req_rx_off_a: assert property (VERIFY_REQ |-> !RX_READY)
      else $error("receiving during verify");
   cover property (VERIFY_REQ && VERIFY_DONE && VERIFY_MATCH);
   cover property (VERIFY_REQ && VERIFY_FAULT);
   cover property (TX_VALID && TX_READY && TX_DATA == 8'hab);
endmodule
bind ukv_user_key_verify ukv_user_key_verify_properties u_props (.CLOCK(CLOCK),
   .RESETN(RESETN), .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
   .TX_READY(TX_READY), .VERIFY_ADDR(VERIFY_ADDR), .VERIFY_REQ(VERIFY_REQ),
   .VERIFY_DONE(VERIFY_DONE), .VERIFY_MATCH(VERIFY_MATCH), .VERIFY_FAULT(VERIFY_FAULT),
   .UNRESPONSIVE(UNRESPONSIVE));

// ### verif/ukv_user_key_verify_test.sv
// Self-checking bench for the user key verify block
`timescale 1ns/100ps
module ukv_user_key_verify_test;
   logic        clk = 1'b0, rst_n = 1'b0, rxv = 1'b0, slow = 1'b0;
   logic        dn = 1'b0, mt = 1'b0, ft = 1'b0, match_m = 1'b1, fault_m = 1'b0;
   logic [7:0]  rxd = 8'h00, wau_u = 8'h80, wau_d = 8'h04;
   logic [31:0] lim_hi = 32'h08000fff, exp_adr = 32'h0;
   logic [3:0]  vc = 4'h0;
   logic        rxr, txv, txr, vreq, hung;
   logic [7:0]  txd, vtyp, exp_typ = 8'h00, cmd_b = 8'h2b;
   logic [31:0] vadr;
   int          fails = 0, checked = 0, cyc = 0, base = 0;
   ukv_user_key_verify u_ukv_user_key_verify (.CLOCK(clk), .RESETN(rst_n), .RX_DATA(rxd),
      .RX_VALID(rxv), .RX_READY(rxr), .TX_DATA(txd), .TX_VALID(txv), .TX_READY(txr),
      .USER_AREA_START(32'h0), .USER_AREA_END(32'h0003ffff), .DATA_AREA_START(32'h08000000),
      .DATA_AREA_END(32'h08001fff), .USER_AREA_WRITE_UNIT(wau_u), .DATA_AREA_WRITE_UNIT(wau_d),
      .ACCESS_LIMIT_LOW(32'h0), .ACCESS_LIMIT_HIGH(lim_hi), .VERIFY_REQ(vreq),
      .VERIFY_ADDR(vadr), .VERIFY_TYPE(vtyp), .VERIFY_DONE(dn), .VERIFY_MATCH(mt),
      .VERIFY_FAULT(ft), .UNRESPONSIVE(hung));
   ukv_host_model u_host (.clk(clk), .slow(slow), .tx_data(txd), .tx_valid(txv), .tx_ready(txr));
   initial forever #2 clk = ~clk;
   // Trusted side answers a few cycles into each request
   always @(posedge clk) begin
      vc <= vreq ? vc + 4'h1 : 4'h0;
      dn <= vreq && vc == 4'h2 && !fault_m;
      ft <= vreq && vc == 4'h2 && fault_m;
      mt <= match_m;
      cyc <= cyc + 1;
      if (vreq && vc == 4'h1) chk(vadr, exp_adr);
      if (vreq && vc == 4'h1) chk(vtyp, exp_typ);
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds each byte until the block takes it
   task automatic send(input logic [7:0] b);
      rxd <= b;
      rxv <= 1'b1;
      @(negedge clk);
      while (!rxr) @(negedge clk);
      @(posedge clk);
   endtask
   task automatic pkt(input logic [7:0] ln, input logic [31:0] a, input logic [7:0] t,
                      input logic [7:0] etx, input logic [7:0] bad);
      logic [7:0] b [0:5];
      logic [7:0] s;
      b = '{cmd_b, a[31:24], a[23:16], a[15:8], a[7:0], t};
      s = ln;
      exp_adr = a;
      exp_typ = t;
      send(8'h5a);
      send(8'h01);
      send(8'h00);
      send(ln);
      for (int i = 0; i < ln; i++) begin
         send(b[i]);
         s = s + b[i];
      end
      send(8'h00 - s + bad);
      send(etx);
      rxv <= 1'b0;
   endtask
   task automatic run(input logic [7:0] ln, input logic [31:0] a, input logic [7:0] t,
                      input logic [7:0] etx, input logic [7:0] bad, input logic [7:0] sts);
      logic [7:0] e [0:14];
      logic [7:0] res;
      int n;
      pkt(ln, a, t, etx, bad);
      res = sts == 8'h00 ? 8'h2b : 8'hab;
      e = '{8'h81, 8'h00, 8'h0a, res, sts, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
            8'hff, 8'h00, 8'h03};
      e[13] = sts == 8'h00 ? 8'hd6 : 8'h00 - (8'h0a + res + sts + 8'hf8);
      n = 0;
      while (u_host.cnt < base + 15 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(u_host.cnt, base + 15);
      for (int i = 0; i < 15; i++) chk(u_host.got[(base + i) % 256], e[i]);
      base = base + 15;
   endtask
   task automatic t_frame;
      slow <= 1'b1;
      run(8'h06, 32'h4000, 8'h1f, 8'h04, 8'h00, 8'hc1);
      run(8'h06, 32'h4000, 8'h1f, 8'h03, 8'h01, 8'hc2);
      run(8'h05, 32'h4000, 8'h1f, 8'h03, 8'h00, 8'hc1);
   endtask
   task automatic t_param;
      run(8'h06, 32'h4000, 8'h18, 8'h03, 8'h00, 8'hc3);
      run(8'h06, 32'h4000, 8'h2c, 8'h03, 8'h00, 8'hc3);
      run(8'h06, 32'h00050000, 8'h1f, 8'h03, 8'h00, 8'hc3);
      wau_u <= 8'h08;
      run(8'h06, 32'h4004, 8'h1f, 8'h03, 8'h00, 8'hc3);
      wau_d <= 8'h00;
      run(8'h06, 32'h08000000, 8'h1f, 8'h03, 8'h00, 8'hc3);
      lim_hi <= 32'h00004fff;
      run(8'h06, 32'h5000, 8'h1f, 8'h03, 8'h00, 8'hd0);
      lim_hi <= 32'h08000fff;
   endtask
   task automatic t_verify;
      run(8'h06, 32'h4000, 8'h1f, 8'h03, 8'h00, 8'h00);
      slow <= 1'b0;
      match_m <= 1'b0;
      run(8'h06, 32'h4000, 8'hfe, 8'h03, 8'h00, 8'hcc);
      run(8'h06, 32'h4000, 8'h2b, 8'h03, 8'h00, 8'hcc);
   endtask
   task automatic t_fault;
      // Foreign command code is taken whole and dropped without an answer
      cmd_b = 8'h29;
      pkt(8'h06, 32'h4000, 8'h1f, 8'h03, 8'h00);
      repeat (20) @(posedge clk);
      chk(u_host.cnt, base);
      chk(rxr, 32'h1);
      cmd_b = 8'h2b;
      fault_m <= 1'b1;
      pkt(8'h06, 32'h4000, 8'h1f, 8'h03, 8'h00);
      repeat (40) @(posedge clk);
      chk(hung, 32'h1);
      chk(u_host.cnt, base);
   endtask
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_frame();
      t_param();
      t_verify();
      t_fault();
      end_sim();
   end
endmodule
